// File: rtl/sgc_checker_top.sv
`timescale 1ns/1ps
`include "sgc_defs.svh"
module sgc_checker_top
    import sgc_pkg::*;
#(
    parameter int unsigned NSW            = 8,
    parameter int unsigned SEL_TIMEOUT_CYC = `SGC_SEL_TIME_S * `SGC_CLK_HZ,
    parameter int unsigned PROC_LIMIT_CYC  = `SGC_PROC_TIME_MS * (`SGC_CLK_HZ / 1000),
    parameter int unsigned TICK_CYC        = `SGC_TICK_TIME_US * (`SGC_CLK_HZ / 1000000)
)(
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             access_granted,
    input  wire logic [NSW-1:0]   pos_closed,
    input  wire logic             bay_logic_editor_ok,
    input  wire logic             sys_interlock_ok,
    input  wire logic             parallel_op,
    input  wire logic             prot_block,
    input  wire logic             settings_busy,
    input  wire logic [NSW-1:0]   out_block_active,
    input  wire logic             hw_fault,
    input  wire logic [NSW-1:0]   shared_busy,
    output logic [NSW-1:0]        bo_open,
    output logic [NSW-1:0]        bo_close,
    output logic                  cmd_busy,
    output logic                  cmd_failed,
    output logic                  ack_pending,
    output logic [NSW-1:0]        tag_active,
    output logic [NSW-1:0]        tag_closed,
    output logic [NSW-1:0]        out_blocked,
    output logic                  auth_remote
);
    typedef struct packed {
        sgc_state_t     state;
        sgc_cmd_t       cmd;
        sgc_rsn_t       reason;
        logic           failed;
        logic           done_ok;
        logic           ack_pend;
        logic           refused;
        logic [31:0]    sel_cnt;
        logic [31:0]    proc_cnt;
        logic [31:0]    tick_cnt;
        logic [15:0]    run_cnt;
        logic [NSW-1:0] bo_open;
        logic [NSW-1:0] bo_close;
        logic [NSW-1:0] tag_active;
        logic [NSW-1:0] tag_closed;
        logic [NSW-1:0] out_blocked;
        logic           auth_remote;
        logic [31:0]    prdata;
        logic           pready;
        logic           pslverr;
        logic           busy;
    } sgc_st_t;
    sgc_st_t   r_reg;
    sgc_st_t   r_next;
    sgc_cfg_if cfg ();
    initial
    begin
        if (NSW < 1 || NSW > 8)
            $error("NSW must be 1..8");
        if (SEL_TIMEOUT_CYC < 1 || PROC_LIMIT_CYC < 1 || TICK_CYC < 1)
            $error("Timing counts must be at least one cycle");
    end
    sgc_cfg_mem #(.NSW(NSW)) u_cfg_mem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .cfg     (cfg)
    );
    function automatic logic is_cfg_addr(input logic [7:0] a);
        return a >= `SGC_OFS_CFG && 32'((a - `SGC_OFS_CFG) >> 2) < NSW && a[1:0] == 2'h0;
    endfunction
    function automatic logic addr_ok(input logic [7:0] a);
        return a == `SGC_OFS_CMD || a == `SGC_OFS_KEY || a == `SGC_OFS_STAT
            || a == `SGC_OFS_FLAG || is_cfg_addr(a);
    endfunction
    function automatic logic is_interlock(input sgc_rsn_t rs);
        return rs >= SGC_RSN_AUTH && rs <= SGC_RSN_PROT;
    endfunction
    // First failing check, evaluated in the fixed order of the sequence
    function automatic sgc_rsn_t check_cmd(
        input sgc_cmd_t    c,
        input logic [31:0] w,
        input logic        pos_now,
        input logic        auth_r,
        input logic        blk_now,
        input logic        shr_now
    );
        logic tgt_ok;
        logic auth_bad;
        tgt_ok   = 32'(c.target) < NSW;
        auth_bad = (c.src == `SGC_SRC_REMOTE) ? !auth_r
                 : (c.src == `SGC_SRC_AUTO)   ? 1'b0 : auth_r;
        if (hw_fault)
            return SGC_RSN_HW;
        if (!c.internal && !c.test)
        begin
            if (w[`SGC_CFG_IL_AUTH] && auth_bad)
                return SGC_RSN_AUTH;
            if (w[`SGC_CFG_IL_POS] && !c.step && pos_now == c.close)
                return SGC_RSN_POS;
            if (w[`SGC_CFG_IL_BAY] && !bay_logic_editor_ok)
                return SGC_RSN_BAY;
            if (w[`SGC_CFG_IL_SYS] && !sys_interlock_ok)
                return SGC_RSN_SYS;
            if (w[`SGC_CFG_IL_DBL] && parallel_op)
                return SGC_RSN_DBL;
            if (w[`SGC_CFG_IL_PROT] && prot_block)
                return SGC_RSN_PROT;
        end
        if (c.internal)
            return SGC_RSN_NONE;
        if (!tgt_ok || !w[`SGC_CFG_ASSIGNED])
            return SGC_RSN_ABSENT;
        if (w[`SGC_CFG_BLK_PROG] && blk_now)
            return SGC_RSN_OUTBLK;
        if (w[`SGC_CFG_SHARED] && shr_now)
            return SGC_RSN_SHARED;
        return SGC_RSN_NONE;
    endfunction
    sgc_cmd_t            cmd_in;
    logic                deny;
    sgc_rsn_t            deny_rsn;
    sgc_rsn_t            chk;
    wire logic           acc     = psel && penable;
    // A write lands on the edge that the master sees pready high
    wire logic           wr_fire = acc && r_reg.pready && pwrite && !r_reg.pslverr;
    wire logic           cmd_wr  = wr_fire && paddr == `SGC_OFS_CMD;
    wire logic           key_wr  = wr_fire && paddr == `SGC_OFS_KEY;
    wire logic           confirm = key_wr && pwdata[`SGC_KEY_CONFIRM];
    wire logic           cancel  = key_wr && pwdata[`SGC_KEY_CANCEL];
    wire logic           ack     = key_wr && pwdata[`SGC_KEY_ACK];
    wire logic           tgt_ok  = 32'(r_reg.cmd.target) < NSW;
    wire logic [NSW-1:0] tsel    = tgt_ok ? NSW'(1) << r_reg.cmd.target : '0;
    wire logic           pos_now = |(tsel & ((r_reg.tag_active & r_reg.tag_closed)
                                           | (~r_reg.tag_active & pos_closed)));
    assign cmd_in    = sgc_cmd_t'(pwdata[$bits(sgc_cmd_t)-1:0]);
    assign cfg.we    = wr_fire && is_cfg_addr(paddr);
    assign cfg.waddr = 3'((paddr - `SGC_OFS_CFG) >> 2);
    assign cfg.wdata = pwdata;
    assign cfg.raddr = r_reg.cmd.target;
    always_comb
    begin
        r_next   = r_reg;
        deny     = 1'b0;
        deny_rsn = SGC_RSN_NONE;
        // Inside the process so that changes of the interlock pins wake it
        chk      = check_cmd(r_reg.cmd, cfg.rdata, pos_now, r_reg.auth_remote,
                             |(tsel & (out_block_active | r_reg.out_blocked)),
                             |(tsel & shared_busy));
        // Bus answer: one wait cycle so read data leaves a flip-flop
        r_next.pready  = acc && !r_reg.pready;
        r_next.pslverr = acc && !r_reg.pready && !addr_ok(paddr);
        r_next.prdata  = '0;
        if (acc && !r_reg.pready && !pwrite)
        begin
            unique case (paddr)
                `SGC_OFS_CMD:  r_next.prdata = 32'(r_reg.cmd);
                `SGC_OFS_STAT:
                begin
                    r_next.prdata[5:0]                  = r_reg.state;
                    r_next.prdata[`SGC_STAT_BUSY]       = r_reg.state != SGC_IDLE
                                                       && r_reg.state != SGC_ACKW;
                    r_next.prdata[`SGC_STAT_FAILED]     = r_reg.failed;
                    r_next.prdata[`SGC_STAT_ACK]        = r_reg.ack_pend;
                    r_next.prdata[`SGC_STAT_REFUSED]    = r_reg.refused;
                    r_next.prdata[`SGC_STAT_DONE]       = r_reg.done_ok;
                    r_next.prdata[`SGC_STAT_RSN_LSB+:5] = r_reg.reason;
                end
                `SGC_OFS_FLAG:
                begin
                    r_next.prdata[7:0]              = 8'(r_reg.tag_active);
                    r_next.prdata[15:8]             = 8'(r_reg.tag_closed);
                    r_next.prdata[23:16]            = 8'(r_reg.out_blocked);
                    r_next.prdata[`SGC_FLAG_AUTH]   = r_reg.auth_remote;
                end
                default:       r_next.prdata = '0;
            endcase
        end
        unique case (r_reg.state)
            SGC_IDLE:
            begin
                if (cmd_wr)
                begin
                    r_next.cmd      = sgc_cmd_t'(pwdata[$bits(sgc_cmd_t)-1:0]);
                    r_next.failed   = 1'b0;
                    r_next.done_ok  = 1'b0;
                    r_next.refused  = 1'b0;
                    r_next.reason   = SGC_RSN_NONE;
                    r_next.sel_cnt  = '0;
                    r_next.proc_cnt = '0;
                    if (!access_granted)
                    begin
                        deny     = 1'b1;
                        deny_rsn = SGC_RSN_ACCESS;
                    end
                    else if (cmd_in.src == `SGC_SRC_KEYPAD)
                        r_next.state = SGC_SELECT;
                    else
                        r_next.state = SGC_FETCH;
                end
            end
            SGC_SELECT:
            begin
                r_next.sel_cnt = r_reg.sel_cnt + 32'h1;
                if (cancel)
                begin
                    deny     = 1'b1;
                    deny_rsn = SGC_RSN_CANCEL;
                end
                else if (confirm)
                    r_next.state = SGC_FETCH;
                else if (r_reg.sel_cnt >= SEL_TIMEOUT_CYC - 1)
                begin
                    deny     = 1'b1;
                    deny_rsn = SGC_RSN_SEL_TO;
                end
            end
            SGC_FETCH:
            begin
                // Config word is valid one cycle after the target settles
                r_next.proc_cnt = r_reg.proc_cnt + 32'h1;
                r_next.state    = SGC_CHECK;
            end
            SGC_CHECK:
            begin
                r_next.proc_cnt = r_reg.proc_cnt + 32'h1;
                if (cancel && r_reg.cmd.src == `SGC_SRC_KEYPAD)
                begin
                    deny     = 1'b1;
                    deny_rsn = SGC_RSN_CANCEL;
                end
                else if (r_reg.proc_cnt >= PROC_LIMIT_CYC - 1)
                begin
                    deny     = 1'b1;
                    deny_rsn = SGC_RSN_PROC_TO;
                end
                else if (settings_busy)
                    r_next.state = SGC_CHECK;
                else if (chk != SGC_RSN_NONE)
                begin
                    deny     = 1'b1;
                    deny_rsn = chk;
                end
                else if (r_reg.cmd.internal)
                begin
                    unique case (r_reg.cmd.iop)
                        `SGC_IOP_TAG:
                        begin
                            r_next.tag_active = r_reg.cmd.ival ? r_reg.tag_active | tsel
                                                               : r_reg.tag_active & ~tsel;
                            r_next.tag_closed = r_reg.cmd.close ? r_reg.tag_closed | tsel
                                                                : r_reg.tag_closed & ~tsel;
                        end
                        `SGC_IOP_AUTH:   r_next.auth_remote = r_reg.cmd.ival;
                        `SGC_IOP_RESET:  r_next.refused     = 1'b0;
                        `SGC_IOP_OUTBLK:
                            r_next.out_blocked = r_reg.cmd.ival ? r_reg.out_blocked | tsel
                                                                : r_reg.out_blocked & ~tsel;
                    endcase
                    r_next.done_ok = 1'b1;
                    r_next.state   = SGC_IDLE;
                end
                else
                begin
                    r_next.bo_close = r_reg.cmd.close ? tsel : '0;
                    r_next.bo_open  = r_reg.cmd.close ? '0 : tsel;
                    r_next.run_cnt  = '0;
                    r_next.tick_cnt = '0;
                    r_next.state    = SGC_EXEC;
                end
            end
            SGC_EXEC:
            begin
                r_next.tick_cnt = (r_reg.tick_cnt >= TICK_CYC - 1) ? '0
                                                                   : r_reg.tick_cnt + 32'h1;
                if (r_reg.tick_cnt >= TICK_CYC - 1)
                    r_next.run_cnt = r_reg.run_cnt + 16'h1;
                if (cancel)
                begin
                    deny     = 1'b1;
                    deny_rsn = SGC_RSN_CANCEL;
                end
                else if (!r_reg.cmd.step && pos_now == r_reg.cmd.close)
                begin
                    r_next.done_ok = 1'b1;
                    r_next.state   = SGC_IDLE;
                end
                else if (r_reg.run_cnt >= cfg.rdata[`SGC_CFG_RUN_MSB:`SGC_CFG_RUN_LSB])
                begin
                    // Step and set-point pulses end here by design, switching waits fail
                    if (r_reg.cmd.step)
                    begin
                        r_next.done_ok = 1'b1;
                        r_next.state   = SGC_IDLE;
                    end
                    else
                    begin
                        deny     = 1'b1;
                        deny_rsn = SGC_RSN_FEEDBACK;
                    end
                end
                if (r_next.state != SGC_EXEC)
                begin
                    r_next.bo_open  = '0;
                    r_next.bo_close = '0;
                end
            end
            SGC_ACKW:
            begin
                if (ack)
                begin
                    r_next.ack_pend = 1'b0;
                    r_next.state    = SGC_IDLE;
                end
            end
        endcase
        // A command arriving outside idle is refused, the running one untouched
        if (cmd_wr && r_reg.state != SGC_IDLE)
            r_next.refused = 1'b1;
        if (deny)
        begin
            r_next.failed   = 1'b1;
            r_next.reason   = deny_rsn;
            r_next.bo_open  = '0;
            r_next.bo_close = '0;
            if (r_next.cmd.src == `SGC_SRC_KEYPAD && is_interlock(deny_rsn))
            begin
                r_next.ack_pend = 1'b1;
                r_next.state    = SGC_ACKW;
            end
            else
                r_next.state = SGC_IDLE;
        end
        r_next.busy = r_next.state != SGC_IDLE && r_next.state != SGC_ACKW;
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            r_reg       <= '0;
            r_reg.state <= SGC_IDLE;
        end
        else
            r_reg <= r_next;
    end
    assign prdata      = r_reg.prdata;
    assign pready      = r_reg.pready;
    assign pslverr     = r_reg.pslverr;
    assign bo_open     = r_reg.bo_open;
    assign bo_close    = r_reg.bo_close;
    assign cmd_busy    = r_reg.busy;
    assign cmd_failed  = r_reg.failed;
    assign ack_pending = r_reg.ack_pend;
    assign tag_active  = r_reg.tag_active;
    assign tag_closed  = r_reg.tag_closed;
    assign out_blocked = r_reg.out_blocked;
    assign auth_remote = r_reg.auth_remote;
endmodule

// File: rtl/sgc_defs.svh
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH

// Time figures and clock rate
`define SGC_CLK_HZ          10000000
`define SGC_SEL_TIME_S      60
`define SGC_PROC_TIME_MS    1000
`define SGC_TICK_TIME_US    1000

// Register byte offsets
`define SGC_OFS_CMD         8'h00
`define SGC_OFS_KEY         8'h04
`define SGC_OFS_STAT        8'h08
`define SGC_OFS_FLAG        8'h0c
`define SGC_OFS_CFG         8'h20

// Key register bits
`define SGC_KEY_CONFIRM     0
`define SGC_KEY_CANCEL      1
`define SGC_KEY_ACK         2

// Command source codes
`define SGC_SRC_KEYPAD      2'h0
`define SGC_SRC_TOOL        2'h1
`define SGC_SRC_REMOTE      2'h2
`define SGC_SRC_AUTO        2'h3

// Internal command opcodes
`define SGC_IOP_TAG         2'h0
`define SGC_IOP_AUTH        2'h1
`define SGC_IOP_RESET       2'h2
`define SGC_IOP_OUTBLK      2'h3

// Per-switchgear configuration word
`define SGC_CFG_IL_AUTH     0
`define SGC_CFG_IL_POS      1
`define SGC_CFG_IL_BAY      2
`define SGC_CFG_IL_SYS      3
`define SGC_CFG_IL_DBL      4
`define SGC_CFG_IL_PROT     5
`define SGC_CFG_ASSIGNED    6
`define SGC_CFG_BLK_PROG    7
`define SGC_CFG_SHARED      8
`define SGC_CFG_RUN_LSB     16
`define SGC_CFG_RUN_MSB     31

// Status and flag register fields
`define SGC_STAT_BUSY       6
`define SGC_STAT_FAILED     7
`define SGC_STAT_ACK        8
`define SGC_STAT_REFUSED    9
`define SGC_STAT_DONE       10
`define SGC_STAT_RSN_LSB    16
`define SGC_FLAG_AUTH       24

`define SGC_RESET_WORD      32'h0000_0000
`endif

// File: rtl/sgc_pkg.sv
package sgc_pkg;

    typedef enum logic [5:0] {
        SGC_IDLE   = 6'h01,
        SGC_SELECT = 6'h02,
        SGC_FETCH  = 6'h04,
        SGC_CHECK  = 6'h08,
        SGC_EXEC   = 6'h10,
        SGC_ACKW   = 6'h20
    } sgc_state_t;

    typedef enum logic [4:0] {
        SGC_RSN_NONE     = 5'h00,
        SGC_RSN_ACCESS   = 5'h01,
        SGC_RSN_SEL_TO   = 5'h02,
        SGC_RSN_CANCEL   = 5'h03,
        SGC_RSN_AUTH     = 5'h04,
        SGC_RSN_POS      = 5'h05,
        SGC_RSN_BAY      = 5'h06,
        SGC_RSN_SYS      = 5'h07,
        SGC_RSN_DBL      = 5'h08,
        SGC_RSN_PROT     = 5'h09,
        SGC_RSN_PROC_TO  = 5'h0a,
        SGC_RSN_ABSENT   = 5'h0b,
        SGC_RSN_OUTBLK   = 5'h0c,
        SGC_RSN_HW       = 5'h0d,
        SGC_RSN_SHARED   = 5'h0e,
        SGC_RSN_FEEDBACK = 5'h0f
    } sgc_rsn_t;

    // Command word as written to the command register, high bits first
    typedef struct packed {
        logic [1:0] iop;
        logic       ival;
        logic       internal;
        logic       step;
        logic       test;
        logic [1:0] src;
        logic       close;
        logic [2:0] target;
    } sgc_cmd_t;

endpackage

// File: rtl/sgc_cfg_if.sv
`timescale 1ns/1ps
interface sgc_cfg_if;
    logic        we;
    logic [2:0]  waddr;
    logic [31:0] wdata;
    logic [2:0]  raddr;
    logic [31:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: rtl/sgc_cfg_mem.sv
`timescale 1ns/1ps
`include "sgc_defs.svh"
module sgc_cfg_mem
    import sgc_pkg::*;
#(
    parameter int unsigned NSW = 8
)(
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    sgc_cfg_if.mem     cfg
);
    typedef struct packed {
        logic [31:0] rdata;
    } sgc_mem_st_t;

    // Words stay unreset: an unconfigured entry reads as unknown until it is written
    logic [31:0] mem_reg [NSW];
    sgc_mem_st_t st_reg;
    sgc_mem_st_t st_next;

    initial
    begin
        if (NSW < 1 || NSW > 8)
            $error("NSW must be 1..8");
    end

    always_comb
    begin
        st_next       = st_reg;
        st_next.rdata = (32'(cfg.raddr) < NSW) ? mem_reg[cfg.raddr] : `SGC_RESET_WORD;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
        if (cfg.we && 32'(cfg.waddr) < NSW)
            mem_reg[cfg.waddr] <= cfg.wdata;
    end

    assign cfg.rdata = st_reg.rdata;
endmodule

// File: dv/sgc_fb_model.sv
`timescale 1ns/1ps
module sgc_fb_model (
    input  wire logic [7:0] bo_open,
    input  wire logic [7:0] bo_close,
    input  wire logic       clk_sys,
    input  wire logic [3:0] lag,
    input  wire logic       stuck,
    output logic [7:0]      pos_closed
);
    int cnt = 0;
    initial pos_closed = 8'h00;
    // Contacts move only after lag cycles of drive; stuck never moves
    always @(posedge clk_sys)
    begin
        cnt <= |(bo_open | bo_close) ? cnt + 1 : 0;
        if (!stuck && cnt >= lag)
            pos_closed <= (pos_closed | bo_close) & ~bo_open;
    end
endmodule

// File: dv/sgc_checker_top_sva.sv
`timescale 1ns/1ps
module sgc_checker_top_sva #(parameter int unsigned NSW = 8)(
    input wire logic           clk_sys,
    input wire logic           rst_n,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pready,
    input wire logic           settings_busy,
    input wire logic           hw_fault,
    input wire logic [NSW-1:0] bo_open,
    input wire logic [NSW-1:0] bo_close,
    input wire logic           cmd_busy,
    input wire logic           cmd_failed,
    input wire logic           ack_pending
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    wire logic [NSW-1:0] outs = bo_open | bo_close;
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_access: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_one_switch: assert property ($onehot0(outs))
        else $error("two outputs");
    a_out_busy: assert property (|outs |-> cmd_busy)
        else $error("output while idle");
    a_hw_first: assert property ($rose(|outs) |-> !$past(hw_fault))
        else $error("output despite fault");
    a_settle_first: assert property ($rose(|outs) |-> !$past(settings_busy))
        else $error("output during settings change");
    a_ack_quiet: assert property (ack_pending |-> outs == '0)
        else $error("output while awaiting ack");
    a_fail_quiet: assert property (cmd_failed |-> outs == '0)
        else $error("output after failure");
    cover property ($rose(|bo_close));
    cover property ($rose(ack_pending));
    cover property ($rose(cmd_failed));
endmodule
bind sgc_checker_top sgc_checker_top_sva #(.NSW(NSW)) i_sgc_checker_top_sva (.*);

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic pready, pslverr, cmd_busy, cmd_failed, ack_pending, auth_remote, stuck;
    logic access_granted, bay_logic_editor_ok, sys_interlock_ok, parallel_op;
    logic prot_block, settings_busy, hw_fault;
    logic [3:0] lag = 0;
    logic [7:0] paddr = 0, pos_closed, out_block_active, shared_busy, bo_open, bo_close;
    logic [7:0] tag_active, tag_closed, out_blocked;
    logic [9:0] f = 0;
    logic [31:0] pwdata = 0, prdata, st, w;
    int n_errors = 0, checks_done = 0, seed = 35805, q[$], e;
    wire [31:0] rsn = {27'h0, st[20:16]};
    assign {access_granted, stuck} = {!f[9], f[8]};
    assign {shared_busy, out_block_active} = {{8{f[7]}}, {8{f[6]}}};
    assign {settings_busy, hw_fault, prot_block, parallel_op} = f[5:2];
    assign {sys_interlock_ok, bay_logic_editor_ok} = ~f[1:0];
    always #50 clk_sys = ~clk_sys;
    sgc_checker_top #(.SEL_TIMEOUT_CYC(50), .PROC_LIMIT_CYC(20), .TICK_CYC(4))
        i_sgc_checker_top (.*);
    sgc_fb_model i_sgc_fb_model (.*);
    task automatic check(input logic [31:0] s, x);
        checks_done++;
        if (s !== x)
            n_errors++;
        if (s !== x)
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys) penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        st = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic poll();
        repeat (40)
        begin
            apb(0, 8'h08, 0);
            if (st[6] !== 1'b1)
                break;
        end
    endtask
    // Single fault at a time, so its index gives the reason
    function automatic int model();
        if (f[9]) return 'h1;
        if (f[5:4] != 0) return f[5] ? 'ha : 'hd;
        if (f[3:0] != 0 && !w[6]) return 'h6 + $clog2(f[3:0]);
        if (w[2:0] == 3'h7) return 'hb;
        if (f[7:6] != 0) return f[6] ? 'hc : 'he;
        return (f[8] && pos_closed[w[2:0]] != w[3]) ? 'hf : 'h0;
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #1500000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1;
        @(posedge clk_sys);
        apb(0, 8'h0c, 0);
        check(st, 32'h0);
        apb(0, 8'h10, 0);
        check(32'(err), 32'h1);
        for (int i = 0; i < 8; i++)
            apb(1, 8'(32 + 4 * i), i == 7 ? 32'h0008_01bc : 32'h0008_01fc);
        for (int k = 0; k < 22; k++)
        begin
            w = $random(seed);
            w = (w & 32'h4f) | 32'(k % 3 + 1) << 4;
            f <= (k % 11 == 10) ? 10'h0 : 10'h1 << (k % 11);
            lag <= 4'($random(seed));
            @(posedge clk_sys);
            q.push_back(model());
            apb(1, 8'h00, w);
            poll();
            e = q.pop_front();
            check(rsn, 32'(e));
            if (e == 0 && !f[8])
                check(32'(pos_closed[w[2:0]]), 32'(w[3]));
            $display("test %0d done", k);
        end
        f <= 0;
        apb(1, 8'h00, 32'h0000_0710);
        poll();
        apb(1, 8'h00, 32'h0000_031a);
        poll();
        apb(0, 8'h0c, 0);
        check(st, 32'h0100_0404);
        check(32'({bo_open, bo_close}), 32'h0);
        $display("internal test done");
        apb(1, 8'h00, 32'h09);
        apb(1, 8'h04, 32'h2);
        poll();
        check(rsn, 32'h3);
        apb(1, 8'h00, 32'h09);
        poll();
        check(rsn, 32'h2);
        f <= 1;
        apb(1, 8'h00, 32'h09);
        apb(1, 8'h04, 32'h1);
        poll();
        check(rsn, 32'h6);
        check(32'(ack_pending), 32'h1);
        apb(1, 8'h00, 32'h09);
        apb(0, 8'h08, 0);
        check(32'(st[9]), 32'h1);
        apb(1, 8'h04, 32'h4);
        check(32'(ack_pending), 32'h0);
        $display("keypad test done");
        end_sim();
    end
endmodule
